//--- src/dlsw_pkg.sv
// Shared constants and types for the DLL switch and clock change sequencer
package dlsw_pkg;
	// Register byte offsets
	localparam logic [11:0] ADDR_STATUS   = 12'h000;
	localparam logic [11:0] ADDR_FLAGS    = 12'h004;
	localparam logic [11:0] ADDR_LOCK_CFG = 12'h008;
	localparam logic [11:0] ADDR_HOLD_CFG = 12'h00C;
	localparam logic [11:0] ADDR_SRX_CFG  = 12'h010;
	localparam logic [11:0] ADDR_MR_BASE  = 12'h020;
	localparam logic [11:0] ADDR_MR_LAST  = 12'h02C;
	// Status fields
	localparam int ST_DLL_ON_BIT   = 0;
	localparam int ST_LOCKED_BIT   = 1;
	localparam int ST_SREF_BIT     = 2;
	localparam int ST_PDN_BIT      = 3;
	localparam int ST_CLK_IGN_BIT  = 4;
	localparam int ST_EXIT_WT_BIT  = 5;
	// Sticky flag fields
	localparam int FL_EXIT_CMD_BIT  = 0;
	localparam int FL_EARLY_CMD_BIT = 1;
	localparam int FL_W             = 2;
	// Mode register layout
	localparam int MR_W            = 16;
	localparam int MR_IDX_W        = 2;
	localparam int MR_DEPTH        = 4;
	localparam int MR_DLL_DIS_BIT  = 0;
	localparam int MR_DLL_RST_BIT  = 8;
	localparam logic [1:0] LATENCY_MR_IDX  = 2'h0;
	localparam logic [1:0] TERM_DLL_MR_IDX = 2'h1;
	localparam logic [15:0] MR_RST = 16'h0000;
	// Pin bundle layout
	localparam int PIN_W       = 25;
	localparam int PIN_CKE     = 24;
	localparam int PIN_ODT     = 23;
	localparam int PIN_CS_N    = 22;
	localparam int PIN_RAS_N   = 21;
	localparam int PIN_CAS_N   = 20;
	localparam int PIN_WE_N    = 19;
	localparam int PIN_BA_LO   = 16;
	localparam int PIN_ADDR_LO = 0;
	// Timing counts in memory clock cycles, reset values of the config registers
	localparam logic [15:0] LOCK_CYC_RST = 16'h0200;
	localparam logic [7:0]  HOLD_CYC_RST = 8'h05;
	localparam logic [15:0] SRX_CYC_RST  = 16'h0100;

	typedef enum logic [2:0] {
		CMD_DES,
		CMD_NOP,
		CMD_MRS,
		CMD_REF,
		CMD_OTHER
	} dlsw_cmd_t;

	typedef enum logic [1:0] {
		DEV_IDLE,
		DEV_SREF,
		DEV_PDN
	} dlsw_dev_t;
endpackage : dlsw_pkg

//--- src/dlsw_mr_if.sv
// Write and read port of the mode register store
`timescale 1ns/100ps
interface dlsw_mr_if;
	import dlsw_pkg::*;
	logic                wr_en;
	logic [MR_IDX_W-1:0] wr_idx;
	logic [MR_W-1:0]     wr_data;
	logic [MR_IDX_W-1:0] rd_idx;
	logic [MR_W-1:0]     rd_data;
	modport store (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
	modport user (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
endinterface : dlsw_mr_if

//--- src/dlsw_mr_store.sv
// Mode register store with registered read data
`timescale 1ns/100ps
module dlsw_mr_store (
	input  wire logic   pclk,      // Clock
	input  wire logic   presetn,   // Async reset, active low
	dlsw_mr_if.store    mr         // Write and read port
);
	import dlsw_pkg::*;

	typedef struct packed {
		logic [MR_DEPTH-1:0][MR_W-1:0] mem;
		logic [MR_W-1:0]               rd;
	} dlsw_mrs_t;

	dlsw_mrs_t st_ff;
	dlsw_mrs_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (mr.wr_en) begin
			nxt_st.mem[mr.wr_idx] = mr.wr_data;
		end
		nxt_st.rd = st_ff.mem[mr.rd_idx];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign mr.rd_data = st_ff.rd;
endmodule : dlsw_mr_store

//--- src/dlsw_seq.sv
// Device side DLL on/off and clock change tracker with APB registers
// Notes on behaviour
// - Writing the DLL-disable bit as 1 turns the DLL off until written 0.
// - Writing the DLL reset bit as 1 starts a DLL reset and relock; the code ignores it while the DLL is disabled.
// - During relock, enable high, termination low; after lock, new frequency used. The code checks neither cke nor termination_ctl_pin during relock.
// - In self refresh past the clock hold time the input clock is ignored.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module dlsw_seq (
	input  wire logic        pclk,          // Memory clock
	input  wire logic        presetn,       // Async reset, active low
	input  wire logic        psel,          // APB select
	input  wire logic        penable,       // APB enable
	input  wire logic        pwrite,        // APB direction
	input  wire logic [11:0] paddr,         // APB byte address
	input  wire logic [31:0] pwdata,        // APB write data
	output logic             pready,        // APB ready
	output logic      [31:0] prdata,        // APB read data
	output logic             pslverr,       // APB error on unmapped address
	input  wire logic        cke,           // Clock enable pin
	input  wire logic        termination_ctl_pin, // Termination control pin
	input  wire logic        cs_n,          // Chip select, active low
	input  wire logic        ras_n,         // Row strobe, active low
	input  wire logic        cas_n,         // Column strobe, active low
	input  wire logic        we_n,          // Write enable, active low
	input  wire logic [2:0]  ba,            // Bank address, selects mode register
	input  wire logic [15:0] addr,          // Address, mode register value
	output logic             dll_off,       // DLL disabled
	output logic             dll_locked,    // DLL locked
	output logic             clk_ignored    // Input clock is a don't care
);
	import dlsw_pkg::*;

	typedef struct packed {
		logic [PIN_W-1:0] sync1;
		logic [PIN_W-1:0] sync2;
		logic             prev_cke;
		dlsw_dev_t        dev;
		logic             dll_dis;
		logic             locked;
		logic [15:0]      lock_cnt;
		logic [7:0]       hold_cnt;
		logic             clk_ign;
		logic             in_exit;
		logic [15:0]      srx_cnt;
		logic [FL_W-1:0]  flags;
		logic [15:0]      lock_cfg;
		logic [7:0]       hold_cfg;
		logic [15:0]      srx_cfg;
		logic             pready;
		logic [31:0]      prdata;
		logic             pslverr;
	} dlsw_st_t;

	localparam dlsw_st_t ST_RST = '{
		sync1: '0, sync2: '0, prev_cke: 1'b0, dev: DEV_IDLE, dll_dis: 1'b0,
		locked: 1'b0, lock_cnt: 16'h0000, hold_cnt: 8'h00, clk_ign: 1'b0,
		in_exit: 1'b0, srx_cnt: 16'h0000, flags: '0, lock_cfg: LOCK_CYC_RST,
		hold_cfg: HOLD_CYC_RST, srx_cfg: SRX_CYC_RST, pready: 1'b0,
		prdata: 32'h0000_0000, pslverr: 1'b0};

	dlsw_st_t st_ff;
	dlsw_st_t nxt_st;

	dlsw_mr_if mr_bus ();

	dlsw_mr_store u_mr_store (
		.pclk    (pclk),
		.presetn (presetn),
		.mr      (mr_bus.store)
	);

	function automatic dlsw_cmd_t cmd_of(input logic [PIN_W-1:0] p);
		if (p[PIN_CS_N]) begin
			return CMD_DES;
		end
		unique case ({p[PIN_RAS_N], p[PIN_CAS_N], p[PIN_WE_N]})
			3'b111: return CMD_NOP;
			3'b000: return CMD_MRS;
			3'b001: return CMD_REF;
			default: return CMD_OTHER;
		endcase
	endfunction : cmd_of

	function automatic logic is_mapped(input logic [11:0] a);
		return (a == ADDR_STATUS) || (a == ADDR_FLAGS) || (a == ADDR_LOCK_CFG) ||
			(a == ADDR_HOLD_CFG) || (a == ADDR_SRX_CFG) ||
			((a >= ADDR_MR_BASE) && (a <= ADDR_MR_LAST) && (a[1:0] == 2'b00));
	endfunction : is_mapped

	dlsw_cmd_t           cmd;
	logic                cke_now;
	logic [MR_IDX_W-1:0] mr_idx;
	logic [MR_W-1:0]     mr_val;
	logic                mrs_term;
	logic                mrs_lat;
	logic                apb_wr;
	logic                apb_rd;
	logic [31:0]         status;
	logic [FL_W-1:0]     flag_set;

	always_comb begin
		cmd      = cmd_of(st_ff.sync2);
		cke_now  = st_ff.sync2[PIN_CKE];
		mr_idx   = st_ff.sync2[PIN_BA_LO +: MR_IDX_W];
		mr_val   = st_ff.sync2[PIN_ADDR_LO +: MR_W];
		mrs_term = (cmd == CMD_MRS) && (mr_idx == TERM_DLL_MR_IDX);
		mrs_lat  = (cmd == CMD_MRS) && (mr_idx == LATENCY_MR_IDX);
		// Flag events of this cycle, so that a clear can never swallow one
		flag_set = '0;
		flag_set[FL_EXIT_CMD_BIT]  = st_ff.in_exit && (cmd != CMD_NOP) && (cmd != CMD_DES);
		flag_set[FL_EARLY_CMD_BIT] = (st_ff.lock_cnt != 16'h0000) && (cmd == CMD_OTHER);
		apb_wr   = psel && penable && pwrite && st_ff.pready;
		apb_rd   = psel && penable && !pwrite && !st_ff.pready;
		status   = 32'h0000_0000;
		status[ST_DLL_ON_BIT]  = !st_ff.dll_dis;
		status[ST_LOCKED_BIT]  = st_ff.locked;
		status[ST_SREF_BIT]    = (st_ff.dev == DEV_SREF);
		status[ST_PDN_BIT]     = (st_ff.dev == DEV_PDN);
		status[ST_CLK_IGN_BIT] = st_ff.clk_ign;
		status[ST_EXIT_WT_BIT] = st_ff.in_exit;
	end

	assign mr_bus.wr_en   = (cmd == CMD_MRS);
	assign mr_bus.wr_idx  = mr_idx;
	assign mr_bus.wr_data = mr_val;
	assign mr_bus.rd_idx  = paddr[3:2];

	always_comb begin
		nxt_st = st_ff;
		nxt_st.sync1 = {cke, termination_ctl_pin, cs_n, ras_n, cas_n, we_n, ba, addr};
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.prev_cke = cke_now;

		// Power state from clock enable edges
		unique case (st_ff.dev)
			DEV_IDLE: begin
				if (st_ff.prev_cke && !cke_now) begin
					nxt_st.dev      = (cmd == CMD_REF) ? DEV_SREF : DEV_PDN;
					nxt_st.hold_cnt = st_ff.hold_cfg;
				end
			end
			DEV_SREF, DEV_PDN: begin
				if (!st_ff.prev_cke && cke_now) begin
					nxt_st.dev     = DEV_IDLE;
					nxt_st.clk_ign = 1'b0;
					if (st_ff.dev == DEV_SREF) begin
						nxt_st.in_exit = 1'b1;
						nxt_st.srx_cnt = st_ff.srx_cfg;
					end
				end else if (st_ff.hold_cnt != 8'h00) begin
					nxt_st.hold_cnt = st_ff.hold_cnt - 8'h01;
				end else begin
					nxt_st.clk_ign = 1'b1;
				end
			end
		endcase

		// Self refresh exit wait
		if (st_ff.in_exit) begin
			if ((cmd != CMD_NOP) && (cmd != CMD_DES)) begin
				nxt_st.flags[FL_EXIT_CMD_BIT] = 1'b1;
			end
			if (st_ff.srx_cnt <= 16'h0001) begin
				nxt_st.in_exit = 1'b0;
			end else begin
				nxt_st.srx_cnt = st_ff.srx_cnt - 16'h0001;
			end
		end

		// DLL disable bit and DLL reset with relock count
		if (st_ff.lock_cnt != 16'h0000) begin
			nxt_st.lock_cnt = st_ff.lock_cnt - 16'h0001;
			if (st_ff.lock_cnt == 16'h0001) begin
				nxt_st.locked = 1'b1;
			end
			if (cmd == CMD_OTHER) begin
				nxt_st.flags[FL_EARLY_CMD_BIT] = 1'b1;
			end
		end
		if (mrs_term) begin
			nxt_st.dll_dis = mr_val[MR_DLL_DIS_BIT];
			if (mr_val[MR_DLL_DIS_BIT]) begin
				nxt_st.locked   = 1'b0;
				nxt_st.lock_cnt = 16'h0000;
			end
		end
		if (mrs_lat && mr_val[MR_DLL_RST_BIT] && !st_ff.dll_dis) begin
			nxt_st.locked   = 1'b0;
			nxt_st.lock_cnt = (st_ff.lock_cfg == 16'h0000) ? 16'h0001 : st_ff.lock_cfg;
		end

		// APB slave, one wait state per transfer
		nxt_st.pready = psel && penable && !st_ff.pready;
		if (apb_rd) begin
			nxt_st.pslverr = !is_mapped(paddr);
			unique case (paddr)
				ADDR_STATUS:   nxt_st.prdata = status;
				ADDR_FLAGS:    nxt_st.prdata = {30'h0, st_ff.flags};
				ADDR_LOCK_CFG: nxt_st.prdata = {16'h0000, st_ff.lock_cfg};
				ADDR_HOLD_CFG: nxt_st.prdata = {24'h00_0000, st_ff.hold_cfg};
				ADDR_SRX_CFG:  nxt_st.prdata = {16'h0000, st_ff.srx_cfg};
				default: begin
					nxt_st.prdata = is_mapped(paddr) ? {16'h0000, mr_bus.rd_data}
						: 32'h0000_0000;
				end
			endcase
		end else if (psel && penable && pwrite && !st_ff.pready) begin
			nxt_st.pslverr = !is_mapped(paddr);
			nxt_st.prdata  = 32'h0000_0000;
		end
		if (apb_wr) begin
			unique case (paddr)
				ADDR_FLAGS: begin
					// Clear by writing 1; a new event in the same cycle wins
					nxt_st.flags = (st_ff.flags & ~pwdata[FL_W-1:0]) | flag_set;
				end
				ADDR_LOCK_CFG: nxt_st.lock_cfg = pwdata[15:0];
				ADDR_HOLD_CFG: nxt_st.hold_cfg = pwdata[7:0];
				ADDR_SRX_CFG:  nxt_st.srx_cfg  = pwdata[15:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= ST_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pready      = st_ff.pready;
	assign prdata      = st_ff.prdata;
	assign pslverr     = st_ff.pslverr;
	assign dll_off     = st_ff.dll_dis;
	assign dll_locked  = st_ff.locked;
	assign clk_ignored = st_ff.clk_ign;

	a_dll_off_write: assert property (@(posedge pclk) disable iff (!presetn)
		mrs_term && mr_val[MR_DLL_DIS_BIT] |=> dll_off && !dll_locked)
		else $error("DLL not disabled after disable write");
	a_dll_off_stays: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(dll_off) |-> $past(mrs_term) && $past(mr_val[MR_DLL_DIS_BIT]))
		else $error("DLL disabled without a disable write");
	a_dll_reset_start: assert property (@(posedge pclk) disable iff (!presetn)
		mrs_lat && mr_val[MR_DLL_RST_BIT] && !dll_off && !mrs_term
		|=> !dll_locked && (st_ff.lock_cnt != 16'h0000))
		else $error("DLL reset did not start relock");
	a_lock_on_count: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(dll_locked) |-> $past(st_ff.lock_cnt) == 16'h0001)
		else $error("DLL locked before lock count expired");
	a_clk_ign_state: assert property (@(posedge pclk) disable iff (!presetn)
		clk_ignored |-> (st_ff.dev != DEV_IDLE))
		else $error("Clock ignored outside self refresh or power-down");
	a_clk_ign_hold: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(clk_ignored) |-> $past(st_ff.hold_cnt) == 8'h00)
		else $error("Clock ignored before hold time");

	a_dll_on_write: assert property (@(posedge pclk) disable iff (!presetn)
		mrs_term && !mr_val[MR_DLL_DIS_BIT] |=> !dll_off)
		else $error("DLL not enabled after enable write");
	a_reset_refused: assert property (@(posedge pclk) disable iff (!presetn)
		mrs_lat && mr_val[MR_DLL_RST_BIT] && dll_off
		|=> !dll_locked && (st_ff.lock_cnt == 16'h0000))
		else $error("DLL reset accepted while DLL disabled");
	a_lock_stays: assert property (@(posedge pclk) disable iff (!presetn)
		dll_locked && !mrs_term && !mrs_lat |=> dll_locked)
		else $error("DLL lost lock without a mode command");
	a_clk_ign_exit: assert property (@(posedge pclk) disable iff (!presetn)
		(st_ff.dev != DEV_IDLE) && !st_ff.prev_cke && cke_now |=> !clk_ignored)
		else $error("Clock still ignored after low power exit");
	a_flag_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
		flag_set[FL_EARLY_CMD_BIT] |=> st_ff.flags[FL_EARLY_CMD_BIT])
		else $error("Early command flag not recorded");

	c_sref_clk_ign: cover property (@(posedge pclk) disable iff (!presetn)
		(st_ff.dev == DEV_SREF) && clk_ignored);
	c_dll_relock: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(dll_locked));
	c_pdn_entry: cover property (@(posedge pclk) disable iff (!presetn)
		st_ff.dev == DEV_PDN);
	c_exit_wait_end: cover property (@(posedge pclk) disable iff (!presetn)
		$fell(st_ff.in_exit));
endmodule : dlsw_seq

//--- verification/dlsw_ctl_model.sv
// Memory controller model driving the command, clock enable and termination pins
`timescale 1ns/100ps
module dlsw_ctl_model (
	input  wire logic        pclk,                // Memory clock
	output logic             cke,                 // Clock enable
	output logic             termination_ctl_pin, // Termination control
	output logic             cs_n,                // Chip select, active low
	output logic             ras_n,               // Row strobe, active low
	output logic             cas_n,               // Column strobe, active low
	output logic             we_n,                // Write enable, active low
	output logic [2:0]       ba,                  // Bank address
	output logic [15:0]      addr                 // Address
);
	initial begin
		cke = 1'b1;
		termination_ctl_pin = 1'b0;
		{cs_n, ras_n, cas_n, we_n} = 4'hF;
		ba = 3'h0;
		addr = 16'h0000;
	end

	// One command edge with the given clock enable, then deselect with scrambled lines
	task issue(input logic v, input logic [3:0] c, input logic [2:0] b, input logic [15:0] a);
		@(posedge pclk);
		cke <= v;
		{cs_n, ras_n, cas_n, we_n} <= c;
		ba <= b;
		addr <= a;
		@(posedge pclk);
		{cs_n, ras_n, cas_n, we_n} <= {1'b1, ~c[2:0]};
		ba <= ~b;
		addr <= 16'($urandom);
	endtask : issue
endmodule : dlsw_ctl_model

//--- verification/dlsw_seq_bench.sv
// Self-checking bench for the DLL switch and clock change tracker
`timescale 1ns/100ps
module dlsw_seq_bench;
	import dlsw_pkg::*;
	localparam logic [3:0] K_MRS = 4'b0000;
	localparam logic [3:0] K_REF = 4'b0001;
	localparam logic [3:0] K_ACT = 4'b0011;
	localparam logic [3:0] K_NOP = 4'b0111;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        cke;
	logic        termination_ctl_pin;
	logic        cs_n;
	logic        ras_n;
	logic        cas_n;
	logic        we_n;
	logic [2:0]  ba;
	logic [15:0] addr;
	logic        dll_off;
	logic        dll_locked;
	logic        clk_ignored;
	logic [33:0] exp_q[$];
	logic [33:0] cur;
	logic [15:0] lock_cyc;
	int          err_total;
	int          n_compared;
	int          cyc;

	dlsw_seq u_dlsw_seq (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .cke, .termination_ctl_pin, .cs_n, .ras_n, .cas_n,
		.we_n, .ba, .addr, .dll_off, .dll_locked, .clk_ignored);
	dlsw_ctl_model u_dlsw_ctl_model (.pclk, .cke, .termination_ctl_pin, .cs_n, .ras_n,
		.cas_n, .we_n, .ba, .addr);

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task complete_run;
		if (err_total == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	task chk_apb(input logic [32:0] got, input logic [32:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t apb got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_apb

	task chk_pin(input logic [2:0] exp);
		n_compared++;
		if ({dll_off, dll_locked, clk_ignored} !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t pins got=%h exp=%h", $time, {dll_off, dll_locked, clk_ignored}, exp);
		end
	endtask : chk_pin

	// Expectation word: check-data flag, error, data
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
		exp_q.push_back(e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rd(input logic [11:0] a, input logic [31:0] v);
		apb(1'b0, a, 32'h0000_0000, {2'b10, v});
	endtask : rd

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 34'h0_0000_0000);
	endtask : wr

	task tick(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask : tick

	task cmd(input logic v, input logic [3:0] c, input logic [1:0] b, input logic [15:0] a);
		u_dlsw_ctl_model.issue(v, c, {1'b0, b}, a);
	endtask : cmd

	always @(negedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			cur = exp_q.pop_front();
			chk_apb({pslverr, prdata & {32{cur[33]}}}, cur[32:0]);
		end
	end

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			err_total++;
			complete_run();
		end
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		cyc = 0;
		err_total = 0;
		n_compared = 0;
		void'($urandom(28));
		lock_cyc = 16'd6 + 16'($urandom % 6);
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(ADDR_LOCK_CFG, {16'h0000, LOCK_CYC_RST});
		rd(ADDR_HOLD_CFG, {24'h00_0000, HOLD_CYC_RST});
		rd(ADDR_SRX_CFG, {16'h0000, SRX_CYC_RST});
		rd(ADDR_STATUS, 32'h0000_0001);
		apb(1'b1, 12'h014, 32'hFFFF_FFFF, 34'h1_0000_0000);
		wr(ADDR_LOCK_CFG, {16'h0000, lock_cyc});
		wr(ADDR_HOLD_CFG, 32'h0000_0003);
		wr(ADDR_SRX_CFG, 32'h0000_0010);
		rd(ADDR_LOCK_CFG, {16'h0000, lock_cyc});
		cmd(1'b1, K_MRS, LATENCY_MR_IDX, 16'h0100);
		tick(1);
		cmd(1'b1, K_ACT, 2'h0, 16'h0000);
		tick(int'(lock_cyc) + 6);
		chk_pin(3'b010);
		rd(ADDR_FLAGS, 32'h0000_0002);
		wr(ADDR_FLAGS, 32'h0000_0002);
		rd(ADDR_FLAGS, 32'h0000_0000);
		// On to off: disable, refused reset, self refresh, exit
		cmd(1'b1, K_MRS, TERM_DLL_MR_IDX, 16'h0001);
		tick(4);
		chk_pin(3'b100);
		cmd(1'b1, K_MRS, LATENCY_MR_IDX, 16'h0100);
		tick(int'(lock_cyc) + 6);
		chk_pin(3'b100);
		cmd(1'b0, K_REF, 2'h0, 16'h0000);
		tick(12);
		chk_pin(3'b101);
		rd(ADDR_STATUS, 32'h0000_0014);
		cmd(1'b1, K_NOP, 2'h0, 16'h0000);
		rd(ADDR_STATUS, 32'h0000_0020);
		cmd(1'b1, K_ACT, 2'h0, 16'h0000);
		tick(24);
		cmd(1'b1, K_MRS, LATENCY_MR_IDX, 16'h0030);
		rd(ADDR_FLAGS, 32'h0000_0001);
		wr(ADDR_FLAGS, 32'h0000_0001);
		chk_pin(3'b100);
		// Off to on through self refresh
		cmd(1'b0, K_REF, 2'h0, 16'h0000);
		tick(12);
		cmd(1'b1, K_NOP, 2'h0, 16'h0000);
		tick(24);
		cmd(1'b1, K_MRS, TERM_DLL_MR_IDX, 16'h0000);
		tick(4);
		chk_pin(3'b000);
		cmd(1'b1, K_MRS, LATENCY_MR_IDX, 16'h0100);
		tick(int'(lock_cyc) + 6);
		chk_pin(3'b010);
		rd(ADDR_FLAGS, 32'h0000_0000);
		wr(ADDR_MR_BASE, 32'h0000_FFFF);
		rd(ADDR_MR_BASE, 32'h0000_0100);
		rd(ADDR_MR_BASE + 12'h004, 32'h0000_0000);
		// Precharge power-down clock change window
		cmd(1'b0, K_NOP, 2'h0, 16'h0000);
		tick(12);
		chk_pin(3'b011);
		rd(ADDR_STATUS, 32'h0000_001B);
		cmd(1'b1, K_NOP, 2'h0, 16'h0000);
		tick(4);
		chk_pin(3'b010);
		tick(4);
		complete_run();
	end
endmodule : dlsw_seq_bench
